// ===== rpf_fifo.sv
// Small valid/ready FIFO that decouples the frame builder from the host
module rpf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	// Elaboration check: one entry cannot decouple both sides
	if (WIDTH < 1 || DEPTH < 2) begin
		$error("rpf_fifo: WIDTH must be >= 1 and DEPTH >= 2");
	end

	// Full and empty straight from the occupancy count
	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage; written only, never reset, since occupancy guards reads
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
	end

	// Occupancy
	always_ff @(posedge clk) begin
		if (srst)
			count <= '0;
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end
endmodule

// ===== rpf_emitter.sv
// Receive-packet frame emitter: package and top module
////////////////////////////////////////////////////////////////////////////////
package rpf_pkg;
	// Frame constants
	localparam logic [7:0]  START_DELIM   = 8'h7E;
	localparam logic [7:0]  TYPE_RX       = 8'h90;
	localparam logic [7:0]  CSUM_BASE     = 8'hFF;
	localparam logic [15:0] FIXED_BODY    = 16'h000C;
	localparam logic [15:0] LEN_LIMIT     = 16'hFFF3;
	// Byte offsets inside the frame
	localparam logic [3:0]  IDX_LEN_HI    = 4'h1;
	localparam logic [3:0]  IDX_LEN_LO    = 4'h2;
	localparam logic [3:0]  IDX_TYPE      = 4'h3;
	localparam logic [3:0]  IDX_SRC64     = 4'h4;
	localparam logic [3:0]  IDX_SRC64_END = 4'hB;
	localparam logic [3:0]  IDX_SRC16     = 4'hC;
	localparam logic [3:0]  IDX_SRC16_LO  = 4'hD;
	localparam logic [3:0]  IDX_OPTS      = 4'hE;
	localparam logic [15:0] IDX_PAYLOAD   = 16'h000F;
	// Receive-options bit positions
	localparam int          OPT_ACK       = 0;
	localparam int          OPT_BCAST     = 1;
	localparam int          OPT_SECURE    = 4;
	localparam int          OPT_APS       = 5;
	localparam int          OPT_END_DEV   = 6;
	localparam int          OPT_METHOD    = 6;
	// Register map
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [3:0]  REG_FRAMES    = 4'h8;
	localparam logic [3:0]  REG_DROPS     = 4'hC;
	localparam logic [1:0]  SEL_STANDARD  = 2'h0;
	localparam logic [1:0]  CTRL_SEL_RST  = 2'h0;
	localparam logic        CTRL_ESC_RST  = 1'b0;

	typedef enum {ST_IDLE, ST_HDR, ST_PAY, ST_CSUM, ST_DROP} rpf_state_t;

	// Options byte: every flag ORed in, bits 2 and 3 stay zero
	function automatic logic [7:0] rpf_opts(input logic ack, input logic bcast,
		input logic secure, input logic aps, input logic end_dev, input logic [1:0] method);
		logic [7:0] o;
		o = 8'h00;
		o[OPT_ACK]     = ack;
		o[OPT_BCAST]   = bcast;
		o[OPT_SECURE]  = secure;
		o[OPT_APS]     = aps;
		o[OPT_END_DEV] = end_dev;
		o = o | {method, 6'h00};
		return o;
	endfunction
endpackage

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - With standard output selected, emit one frame for every received packet whose length is within MAX_PAYLOAD.
// - Every frame opens with one start-delimiter byte at offset zero.
// - Offset one holds a two-byte length: bytes between length and checksum.
// - Offset three carries frame type 0x90.
// - Offsets four to eleven carry the sender's 64-bit address.
// - Offsets twelve and thirteen carry the sender's 16-bit network address.
// - Offset fourteen options: bit0 acknowledged, bit1 broadcast, bits 2-3 reserved.
// - Options bit4 secure session, bit5 network security, bit6 end device.
// - Options bits 7:6 encode the mesh delivery method, 00 invalid.
// - Option flags combine by OR; end device and method bit 0 share bit 6.
// - Payload bytes follow from offset fifteen, in received order.
// - Checksum is 0xFF minus low byte of sum from offset three.
// - Multi-byte fields go out most significant byte first.
module rpf_emitter
	import rpf_pkg::*;
#(
	parameter logic [15:0] MAX_PAYLOAD = LEN_LIMIT
) (
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        SRST,
	// Register port
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [31:0]      REG_RDATA,
	// Received packet descriptor
	input  wire logic        PKT_VALID,
	output logic             PKT_READY,
	input  wire logic [63:0] PKT_SRC64,
	input  wire logic [15:0] PKT_SRC16,
	input  wire logic        PKT_ACKED,
	input  wire logic        PKT_BCAST,
	input  wire logic        PKT_SECURE,
	input  wire logic        PKT_APS,
	input  wire logic        PKT_END_DEV,
	input  wire logic [1:0]  PKT_METHOD,
	input  wire logic [15:0] PKT_LEN,
	// Received payload bytes
	input  wire logic        PAY_VALID,
	output logic             PAY_READY,
	input  wire logic [7:0]  PAY_DATA,
	// Serial API byte stream
	output logic             OUT_VALID,
	input  wire logic        OUT_READY,
	output logic [7:0]       OUT_DATA,
	output logic             OUT_LAST
);
	rpf_state_t  state;
	logic [3:0]  idx;
	logic [15:0] left;
	logic [7:0]  sum;
	logic [63:0] src64;
	logic [15:0] src16;
	logic [7:0]  opts;
	logic [15:0] body_len;
	logic [1:0]  api_output_select;
	logic        api_escape_select;
	logic [15:0] frames;
	logic [15:0] drops;
	logic        pkt_take;
	logic        bi_valid;
	logic        bi_ready;
	logic [7:0]  bi_data;
	logic        bi_last;
	logic        bi_fire;
	logic        pay_fire;
	logic        accept_ok;

	// Elaboration check: the length field must hold twelve plus the payload
	if (MAX_PAYLOAD > LEN_LIMIT) begin
		$error("rpf_emitter: MAX_PAYLOAD too large for the length field");
	end

	// Header byte at a given offset, big-endian fields
	function automatic logic [7:0] hdr_byte(input logic [3:0] i, input logic [15:0] l,
		input logic [63:0] a64, input logic [15:0] a16, input logic [7:0] o);
		logic [7:0] b;
		b = START_DELIM;
		if (i == IDX_LEN_HI)
			b = l[15:8];
		else if (i == IDX_LEN_LO)
			b = l[7:0];
		else if (i == IDX_TYPE)
			b = TYPE_RX;
		else if (i >= IDX_SRC64 && i <= IDX_SRC64_END)
			b = 8'(a64 >> {IDX_SRC64_END - i, 3'h0});
		else if (i == IDX_SRC16)
			b = a16[15:8];
		else if (i == IDX_SRC16_LO)
			b = a16[7:0];
		else if (i == IDX_OPTS)
			b = o;
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Handshakes
	assign PKT_READY = (state == ST_IDLE);
	assign pkt_take  = PKT_VALID && PKT_READY;
	assign accept_ok = (api_output_select == SEL_STANDARD) && (PKT_LEN <= MAX_PAYLOAD);
	assign PAY_READY = (state == ST_DROP) || (state == ST_PAY && bi_ready);
	assign pay_fire  = PAY_VALID && PAY_READY;
	assign bi_fire   = bi_valid && bi_ready;

	// Byte offered to the buffer in each state
	always_comb begin
		bi_valid = 1'b0;
		bi_data  = 8'h00;
		bi_last  = 1'b0;
		unique case (state)
			ST_IDLE, ST_DROP: begin
				bi_valid = 1'b0;
			end
			ST_HDR: begin
				bi_valid = 1'b1;
				bi_data  = hdr_byte(idx, body_len, src64, src16, opts);
			end
			ST_PAY: begin
				bi_valid = PAY_VALID;
				bi_data  = PAY_DATA;
			end
			ST_CSUM: begin
				bi_valid = 1'b1;
				bi_data  = CSUM_BASE - sum;
				bi_last  = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer; other output modes swallow the payload unseen
	always_ff @(posedge MCLK) begin
		if (SRST)
			state <= ST_IDLE;
		else begin
			unique case (state)
				ST_IDLE: begin
					if (pkt_take && accept_ok)
						state <= ST_HDR;
					else if (pkt_take && PKT_LEN != 16'h0000)
						state <= ST_DROP;
				end
				ST_HDR: begin
					if (bi_fire && idx == IDX_OPTS)
						state <= (left == 16'h0000) ? ST_CSUM : ST_PAY;
				end
				ST_PAY: begin
					if (pay_fire && left == 16'h0001)
						state <= ST_CSUM;
				end
				ST_CSUM: begin
					if (bi_fire)
						state <= ST_IDLE;
				end
				ST_DROP: begin
					if (pay_fire && left == 16'h0001)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// Header offset counter
	always_ff @(posedge MCLK) begin
		if (SRST || state == ST_IDLE)
			idx <= 4'h0;
		else if (state == ST_HDR && bi_fire)
			idx <= idx + 4'h1;
	end

	// Payload bytes still expected
	always_ff @(posedge MCLK) begin
		if (SRST)
			left <= 16'h0000;
		else if (pkt_take)
			left <= PKT_LEN;
		else if (pay_fire)
			left <= left - 16'h0001;
	end

	// Running sum from the type byte onward
	always_ff @(posedge MCLK) begin
		if (SRST || state == ST_IDLE)
			sum <= 8'h00;
		else if (bi_fire && !bi_last && (state == ST_PAY || idx >= IDX_TYPE))
			sum <= sum + bi_data;
	end

	// Packet fields held for the duration of the frame
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			src64    <= 64'h0;
			src16    <= 16'h0000;
			opts     <= 8'h00;
			body_len <= 16'h0000;
		end else if (pkt_take) begin
			src64    <= PKT_SRC64;
			src16    <= PKT_SRC16;
			// Flags may overlap on bit 6; OR merges end device and method bit 0 there
			opts     <= rpf_opts(PKT_ACKED, PKT_BCAST, PKT_SECURE, PKT_APS,
				PKT_END_DEV, PKT_METHOD);
			body_len <= FIXED_BODY + PKT_LEN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-entry buffer so a stalled host loses no byte
	rpf_fifo #(
		.WIDTH (9),
		.DEPTH (2)
	) u_fifo (
		.clk       (MCLK),
		.srst      (SRST),
		.in_valid  (bi_valid),
		.in_ready  (bi_ready),
		.in_data   ({bi_last, bi_data}),
		.out_valid (OUT_VALID),
		.out_ready (OUT_READY),
		.out_data  ({OUT_LAST, OUT_DATA})
	);

	////////////////////////////////////////////////////////////////////////////
	// Control register
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			api_output_select <= CTRL_SEL_RST;
			api_escape_select <= CTRL_ESC_RST;
		end else if (REG_WR && REG_ADDR == REG_CTRL) begin
			api_output_select <= REG_WDATA[1:0];
			api_escape_select <= REG_WDATA[2];
		end
	end

	// Frame and drop counters, cleared by writing their offset unless a count lands in the same cycle
	always_ff @(posedge MCLK) begin
		if (SRST)
			frames <= 16'h0000;
		else if (state == ST_CSUM && bi_fire)
			frames <= frames + 16'h0001;
		else if (REG_WR && REG_ADDR == REG_FRAMES)
			frames <= 16'h0000;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			drops <= 16'h0000;
		else if (pkt_take && !accept_ok)
			drops <= drops + 16'h0001;
		else if (REG_WR && REG_ADDR == REG_DROPS)
			drops <= 16'h0000;
	end

	// Read data one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge MCLK) begin
		if (SRST)
			REG_RDATA <= 32'h0;
		else if (REG_RD) begin
			unique case (REG_ADDR)
				REG_CTRL:   REG_RDATA <= {29'h0, api_escape_select, api_output_select};
				REG_STATUS: REG_RDATA <= {30'h0, OUT_VALID, state != ST_IDLE};
				REG_FRAMES: REG_RDATA <= {16'h0, frames};
				REG_DROPS:  REG_RDATA <= {16'h0, drops};
				default:    REG_RDATA <= 32'h0;
			endcase
		end else
			REG_RDATA <= 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Output-side observers: byte offset and sum of what the host sees
	logic [15:0] ocnt;
	logic [7:0]  osum;
	logic [15:0] olen;
	logic        ofire;
	assign ofire = OUT_VALID && OUT_READY;

	always_ff @(posedge MCLK) begin
		if (SRST || (ofire && OUT_LAST)) begin
			ocnt <= 16'h0000;
			osum <= 8'h00;
		end else if (ofire) begin
			ocnt <= ocnt + 16'h0001;
			if (ocnt >= 16'(IDX_TYPE))
				osum <= osum + OUT_DATA;
			// Length as the host saw it; a fresh descriptor cannot skew the check
			if (ocnt == 16'(IDX_LEN_HI) || ocnt == 16'(IDX_LEN_LO))
				olen <= {olen[7:0], OUT_DATA};
		end
	end

	start_byte_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && ocnt == 16'h0000 |-> OUT_DATA == 8'h7E && !OUT_LAST)
		else $error("frame does not open with the start delimiter");

	length_field_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && ocnt == 16'h0002 |-> OUT_DATA == body_len[7:0])
		else $error("length low byte wrong");

	type_code_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && ocnt == 16'h0003 |-> OUT_DATA == 8'h90)
		else $error("frame type byte is not 0x90");

	src_addr_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && ocnt == 16'h0004 |-> OUT_DATA == src64[63:56])
		else $error("64-bit source not sent high byte first");

	net_addr_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && ocnt == 16'h000D |-> OUT_DATA == src16[7:0])
		else $error("16-bit source low byte wrong");

	opts_byte_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && ocnt == 16'h000E |-> OUT_DATA[3:2] == 2'b00 && OUT_DATA == opts)
		else $error("receive-options byte wrong");

	frame_len_a: assert property (@(posedge MCLK) disable iff (SRST)
		ofire && OUT_LAST |-> ocnt == olen + 16'h0003)
		else $error("frame length disagrees with the length field");

	checksum_a: assert property (@(posedge MCLK) disable iff (SRST)
		OUT_VALID && OUT_LAST |-> OUT_DATA == 8'hFF - osum)
		else $error("checksum byte wrong");

	emit_start_a: assert property (@(posedge MCLK) disable iff (SRST)
		pkt_take && api_output_select == 2'h0 && PKT_LEN <= MAX_PAYLOAD
		|=> state == ST_HDR ##1 OUT_VALID)
		else $error("standard-output packet did not start a frame");

	drop_quiet_a: assert property (@(posedge MCLK) disable iff (SRST)
		state == ST_DROP |-> !bi_valid && PAY_READY)
		else $error("dropped packet leaked bytes");
endmodule

// ===== rpf_host.sv
// Host model that drains the serial API byte stream and vets each frame
module rpf_host (
	// Clock and reset
	input  wire logic       MCLK,
	input  wire logic       SRST,
	// Byte stream
	input  wire logic       OUT_VALID,
	output logic            OUT_READY,
	input  wire logic [7:0] OUT_DATA,
	input  wire logic       OUT_LAST,
	// Pacing
	input  wire logic       slow
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx[$];
	logic [7:0] cur[$];
	logic [7:0] sum;
	logic [1:0] pace = 2'h0;
	int         frames = 0;
	int         bad = 0;
	initial OUT_READY = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// Take bytes; a slow host stalls three cycles of four to fill the buffer
	always @(posedge MCLK) begin
		pace <= pace + 2'h1;
		OUT_READY <= !SRST && (!slow || pace == 2'h0);
		if (OUT_VALID && OUT_READY) begin
			cur.push_back(OUT_DATA);
			if (OUT_LAST) begin
				sum = 8'h00;
				// Each field is taken as it stands; only the checksum from offset three is checked
				for (int i = 3; i < cur.size(); i++) sum = sum + cur[i];
				if (sum == 8'hFF) begin
					rx = {rx, cur};
					frames++;
				end else begin
					bad++; // Discarded, never reaches rx
				end
				cur.delete();
			end
		end
	end
endmodule

// ===== tb.sv
// Self-checking testbench for the receive-packet frame emitter
module tb import rpf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MAXP = 16'h0010; // Small limit keeps a refused length cheap
	logic        mclk = 1'b0, srst = 1'b1, slow = 1'b0;
	logic        reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        pkt_valid = 1'b0, pkt_ready, pay_valid = 1'b0, pay_ready;
	logic [63:0] src64 = 64'h0;
	logic [15:0] src16 = 16'h0, plen = 16'h0;
	logic [4:0]  flg = 5'h00; // ack, bcast, secure, aps, end device
	logic [1:0]  meth = 2'h0;
	logic [7:0]  pay_data = 8'h00, out_data;
	logic        out_valid, out_ready, out_last;
	logic [7:0]  exp[$];
	logic [7:0]  pl[$];
	int          fail_count = 0, total_checks = 0, cycles = 0;

	rpf_emitter #(.MAX_PAYLOAD(MAXP)) uut (.MCLK(mclk), .SRST(srst), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.PKT_VALID(pkt_valid), .PKT_READY(pkt_ready), .PKT_SRC64(src64), .PKT_SRC16(src16),
		.PKT_ACKED(flg[0]), .PKT_BCAST(flg[1]), .PKT_SECURE(flg[2]), .PKT_APS(flg[3]),
		.PKT_END_DEV(flg[4]), .PKT_METHOD(meth), .PKT_LEN(plen), .PAY_VALID(pay_valid),
		.PAY_READY(pay_ready), .PAY_DATA(pay_data), .OUT_VALID(out_valid),
		.OUT_READY(out_ready), .OUT_DATA(out_data), .OUT_LAST(out_last));
	rpf_host host (.MCLK(mclk), .SRST(srst), .OUT_VALID(out_valid), .OUT_READY(out_ready),
		.OUT_DATA(out_data), .OUT_LAST(out_last), .slow(slow));

	////////////////////////////////////////////////////////////////////////////////
	// 40 MHz clock and a hang guard well past the expected run
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	// Compare and count
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	// Register bus: one-cycle strobes, read data only in the following cycle
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input string what);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(what, e, reg_rdata);
	endtask

	// Descriptor then the payload in pl; each held until its ready is seen at an edge
	task automatic send(input logic [63:0] s, input logic [15:0] a, input logic [4:0] f,
		input logic [1:0] m);
		@(posedge mclk);
		{src64, src16, flg, meth} <= {s, a, f, m};
		plen <= 16'(pl.size());
		pkt_valid <= 1'b1;
		do @(negedge mclk); while (pkt_ready !== 1'b1);
		@(posedge mclk);
		pkt_valid <= 1'b0;
		for (int i = 0; i < pl.size(); i++) begin
			pay_valid <= 1'b1;
			pay_data <= pl[i];
			do @(negedge mclk); while (pay_ready !== 1'b1);
			@(posedge mclk);
		end
		pay_valid <= 1'b0;
	endtask

	// Send one packet and compare the whole frame the host accepted
	task automatic frame(input logic [63:0] s, input logic [15:0] a, input logic [4:0] f,
		input logic [1:0] m);
		logic [7:0]  sum;
		logic [7:0]  o;
		logic [15:0] len;
		host.rx.delete();
		send(s, a, f, m);
		len = 16'h000C + 16'(pl.size());
		o = {m, 6'h00} | {1'b0, f[4], f[3], f[2], 2'h0, f[1], f[0]};
		exp = {8'h7E, len[15:8], len[7:0], 8'h90};
		for (int i = 7; i >= 0; i--) exp.push_back(s[8*i +: 8]);
		exp = {exp, a[15:8], a[7:0], o, pl};
		sum = 8'h00;
		for (int i = 3; i < exp.size(); i++) sum = sum + exp[i];
		exp.push_back(8'hFF - sum);
		for (int k = 0; k < 2000 && host.rx.size() < exp.size(); k++) @(negedge mclk);
		chk("frame size", exp.size(), host.rx.size());
		for (int i = 0; i < exp.size() && i < host.rx.size(); i++)
			chk($sformatf("byte %0d", i), exp[i], host.rx[i]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Unicast sample with acknowledge and a six-byte payload
	task automatic t_example();
		pl = {8'h54, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
		frame(64'h0013A20087654321, 16'h5614, 5'h01, 2'h0);
		chk("sample length", 8'h12, host.rx[2]);
		chk("sample checksum", 8'hB9, host.rx[21]);
	endtask

	// Every flag alone, all together, every method, lengths zero to the limit, host stalling
	task automatic t_opts();
		logic [4:0] f;
		for (int i = 0; i < 9; i++) begin
			f = (i < 5) ? 5'(1 << i) : ((i == 5) ? 5'h1F : 5'h00);
			pl.delete();
			for (int j = 0; j < ((i == 8) ? 16 : 2 * i); j++) pl.push_back(8'(16 * i + j));
			slow <= i[0];
			frame({8'(i), 56'hF0E1D2C3B4A596}, 16'(16'hA55A ^ i), f, i[1:0]);
		end
		slow <= 1'b0;
	endtask

	// Refusals: non-standard output, then a length past the limit; counters and map
	task automatic t_drop();
		host.rx.delete();
		reg_write(REG_CTRL, 32'h5);
		reg_read(REG_CTRL, 32'h5, "ctrl");
		pl = {8'h01, 8'h02, 8'h03};
		send(64'h1, 16'h2, 5'h01, 2'h1);
		reg_write(REG_CTRL, 32'h0);
		pl.delete();
		for (int j = 0; j < 17; j++) pl.push_back(8'(j));
		send(64'h3, 16'h4, 5'h00, 2'h3);
		for (int k = 0; k < 100 && pkt_ready !== 1'b1; k++) @(negedge mclk);
		chk("dropped output", 0, host.rx.size());
		reg_read(REG_STATUS, 32'h0, "status idle");
		reg_read(REG_DROPS, 32'h2, "drops");
		reg_read(REG_FRAMES, 32'hA, "frames");
		reg_write(REG_DROPS, 32'h0);
		reg_read(REG_DROPS, 32'h0, "drops clear");
		reg_read(4'h2, 32'h0, "unmapped");
		chk("bad frames", 0, host.bad);
	endtask

	// Verdict
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Reset for ten cycles, reset values, then the scenarios
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		reg_read(REG_CTRL, 32'h0, "ctrl reset");
		reg_read(REG_FRAMES, 32'h0, "frames reset");
		reg_read(REG_DROPS, 32'h0, "drops reset");
		t_example();
		t_opts();
		t_drop();
		wrap_up();
	end
endmodule
